// >>> src/rotate_exec_regs.vh
`ifndef ROTATE_EXEC_REGS_VH
`define ROTATE_EXEC_REGS_VH
// Contract
// - Opcode 001101da: shift left through carry; C, N, Z updated.
// - Opcode 010001da: rotate left, bit 7 wraps to bit 0; N, Z only.
// - Opcode 001100da: shift right through carry; C, N, Z updated.
// - Opcode 010000da: rotate right, bit 0 wraps to bit 7; N, Z only.
// - Destination bit 0 writes the accumulator, 1 writes the file register.
// - Bank bit 0 uses the access bank, 1 uses the bank pointer.
// - Extended set, bank bit 0 and address up to 5Fh use indexed offset.
// - One word, one cycle: decode, read, process, write destination.

// Register byte addresses.
`define ADDR_CTRL 8'h00
`define ADDR_INSTR 8'h04
`define ADDR_WREG 8'h08
`define ADDR_STATUS 8'h0c
`define ADDR_BANK 8'h10
`define ADDR_INDEX 8'h14
`define ADDR_FADDR 8'h18
`define ADDR_FDATA 8'h1c

// Field positions.
`define CTRL_EXT_BIT 0
`define ST_C_BIT 0
`define ST_Z_BIT 1
`define ST_N_BIT 2
`define ST_BAD_BIT 6
`define ST_BUSY_BIT 7

// Reset values.
`define RST_CTRL_EXT 1'b0
`define RST_WREG 8'h00
`define RST_INSTR 16'h0000
`define RST_FLAG 1'b0

// Opcode patterns in instruction bits 15..10.
`define OP_RLC 6'h0d
`define OP_RL 6'h11
`define OP_RRC 6'h0c
`define OP_RR 6'h10

// Indexed offset limit and access bank upper fill.
`define IDX_LIMIT 8'h5f
`define ACC_HI_FILL 1'b1

// Instruction phases.
`define PH_DECODE 2'h0
`define PH_READ 2'h1
`define PH_PROC 2'h2
`define PH_WRITE 2'h3

// Bus responses.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// >>> src/operand_file.v
`timescale 1ns/1ps
`default_nettype none
// Single port data file; read data is registered and shows the old word
// when the same address is written in that cycle.
module operand_file #(
   parameter AW = 12,
   parameter DW = 8
)(
   // Clock
   input wire clk,
   // Port
   input wire we,
   input wire [AW-1:0] addr,
   input wire [DW-1:0] wdata,
   output reg [DW-1:0] rdata_q
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   always @(posedge clk)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
      rdata_q <= mem[addr];
   end
endmodule
`default_nettype wire

// >>> src/rotate_exec.v
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rotate_exec_regs.vh"
module rotate_exec #(
   parameter BANK_W = 4
)(
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Write address channel
   input wire [7:0] awaddr,
   input wire [2:0] awprot,
   input wire awvalid,
   output wire awready,
   // Write data channel
   input wire [31:0] wdata,
   input wire [3:0] wstrb,
   input wire wvalid,
   output wire wready,
   // Write response channel
   output wire [1:0] bresp,
   output wire bvalid,
   input wire bready,
   // Read address channel
   input wire [7:0] araddr,
   input wire [2:0] arprot,
   input wire arvalid,
   output wire arready,
   // Read data channel
   output wire [31:0] rdata,
   output wire [1:0] rresp,
   output wire rvalid,
   input wire rready
);
   localparam AW = BANK_W + 8;
   localparam RD_IDLE = 2'h0;
   localparam RD_WAIT = 2'h1;
   localparam RD_FETCH = 2'h2;
   localparam RD_RESP = 2'h3;

   reg awready_q;
   reg wready_q;
   reg bvalid_q;
   reg [1:0] bresp_q;
   reg arready_q;
   reg rvalid_q;
   reg [1:0] rresp_q;
   reg [31:0] rdata_q;
   reg [1:0] rd_state_q;
   reg [7:0] awaddr_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg [7:0] araddr_q;

   reg ext_en_q;
   reg [15:0] instr_q;
   reg [7:0] wreg_q;
   reg c_q;
   reg z_q;
   reg n_q;
   reg bad_q;
   reg busy_q;
   reg [1:0] phase_q;
   reg [BANK_W-1:0] bank_q;
   reg [AW-1:0] index_q;
   reg [AW-1:0] faddr_q;
   reg [AW-1:0] eaddr_q;
   reg left_q;
   reg carry_q;
   reg dest_q;
   reg [7:0] res_q;
   reg res_c_q;

   wire [7:0] mem_rdata;
   reg [31:0] rd_mux;
   reg [2:0] kind;
   reg [AW-1:0] eaddr_d;
   reg [7:0] res_d;
   reg res_c_d;
   wire [31:0] instr_m;
   wire [31:0] index_m;
   wire [31:0] faddr_m;

   // Returns 1 for every address that holds a register.
   function mapped;
      input [7:0] a;
      begin
         case (a)
            `ADDR_CTRL, `ADDR_INSTR, `ADDR_WREG, `ADDR_STATUS,
            `ADDR_BANK, `ADDR_INDEX, `ADDR_FADDR, `ADDR_FDATA:
               mapped = 1'b1;
            default:
               mapped = 1'b0;
         endcase
      end
   endfunction

   // Merges written byte lanes into the old register value.
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] strb;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
         begin
            if (strb[i])
            begin
               merge[i*8 +: 8] = nw[i*8 +: 8];
            end
         end
      end
   endfunction

   // Decodes the opcode into {valid, left, through carry}.
   function [2:0] op_kind;
      input [5:0] op;
      begin
         case (op)
            `OP_RLC: op_kind = 3'h7;
            `OP_RL: op_kind = 3'h6;
            `OP_RRC: op_kind = 3'h5;
            `OP_RR: op_kind = 3'h4;
            default: op_kind = 3'h0;
         endcase
      end
   endfunction

   wire wr_go = ~awready_q & ~wready_q & ~bvalid_q & ~busy_q;
   wire wr_ok = wr_go & mapped(awaddr_q);
   wire bus_we = wr_ok & (awaddr_q == `ADDR_FDATA) & wstrb_q[0];
   wire exec_we = busy_q & (phase_q == `PH_WRITE) & dest_q;
   wire rd_issue = (rd_state_q == RD_WAIT) & ~busy_q & ~bus_we;

   // Byte lane merges, cut back to each register's width where used.
   assign instr_m = merge({16'h0000, instr_q}, wdata_q, wstrb_q);
   assign index_m = merge({{(32-AW){1'b0}}, index_q}, wdata_q, wstrb_q);
   assign faddr_m = merge({{(32-AW){1'b0}}, faddr_q}, wdata_q, wstrb_q);

   // Execution owns the file port while busy, software otherwise.
   operand_file #(
      .AW(AW),
      .DW(8)
   ) u_file (
      .clk(aclk),
      .we(bus_we | exec_we),
      .addr(busy_q ? eaddr_q : faddr_q),
      .wdata(busy_q ? res_q : wdata_q[7:0]),
      .rdata_q(mem_rdata)
   );

   always @*
   begin
      kind = op_kind(instr_q[15:10]);
      if (~instr_q[8])
      begin
         if (ext_en_q && instr_q[7:0] <= `IDX_LIMIT)
         begin
            eaddr_d = index_q + {{BANK_W{1'b0}}, instr_q[7:0]};
         end
         else if (instr_q[7:0] <= `IDX_LIMIT)
         begin
            eaddr_d = {{BANK_W{1'b0}}, instr_q[7:0]};
         end
         else
         begin
            eaddr_d = {{BANK_W{`ACC_HI_FILL}}, instr_q[7:0]};
         end
      end
      else
      begin
         eaddr_d = {bank_q, instr_q[7:0]};
      end
      if (left_q)
      begin
         res_c_d = mem_rdata[7];
         res_d = {mem_rdata[6:0], carry_q ? c_q : mem_rdata[7]};
      end
      else
      begin
         res_c_d = mem_rdata[0];
         res_d = {carry_q ? c_q : mem_rdata[0], mem_rdata[7:1]};
      end
   end

   always @*
   begin
      rd_mux = 32'h0000_0000;
      case (araddr_q)
         `ADDR_CTRL: rd_mux[`CTRL_EXT_BIT] = ext_en_q;
         `ADDR_INSTR: rd_mux[15:0] = instr_q;
         `ADDR_WREG: rd_mux[7:0] = wreg_q;
         `ADDR_STATUS:
         begin
            rd_mux[`ST_C_BIT] = c_q;
            rd_mux[`ST_Z_BIT] = z_q;
            rd_mux[`ST_N_BIT] = n_q;
            rd_mux[`ST_BAD_BIT] = bad_q;
            rd_mux[`ST_BUSY_BIT] = busy_q;
         end
         `ADDR_BANK: rd_mux[BANK_W-1:0] = bank_q;
         `ADDR_INDEX: rd_mux[AW-1:0] = index_q;
         `ADDR_FADDR: rd_mux[AW-1:0] = faddr_q;
         `ADDR_FDATA: rd_mux[7:0] = mem_rdata;
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Bus handshakes.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rresp_q <= `RESP_OKAY;
         rdata_q <= 32'h0000_0000;
         araddr_q <= 8'h00;
         rd_state_q <= RD_IDLE;
      end
      else
      begin
         if (awvalid && awready_q)
         begin
            awready_q <= 1'b0;
            awaddr_q <= {awaddr[7:2], 2'b00};
         end
         if (wvalid && wready_q)
         begin
            wready_q <= 1'b0;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (wr_go)
         begin
            bvalid_q <= 1'b1;
            bresp_q <= mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (bvalid_q && bready)
         begin
            bvalid_q <= 1'b0;
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
         case (rd_state_q)
            RD_IDLE:
            begin
               if (arvalid)
               begin
                  arready_q <= 1'b0;
                  araddr_q <= {araddr[7:2], 2'b00};
                  if ({araddr[7:2], 2'b00} == `ADDR_FDATA)
                  begin
                     rd_state_q <= RD_WAIT;
                  end
                  else
                  begin
                     rd_state_q <= RD_FETCH;
                  end
               end
            end
            RD_WAIT:
            begin
               if (rd_issue)
               begin
                  rd_state_q <= RD_FETCH;
               end
            end
            RD_FETCH:
            begin
               rdata_q <= rd_mux;
               rresp_q <= mapped(araddr_q) ? `RESP_OKAY : `RESP_SLVERR;
               rvalid_q <= 1'b1;
               rd_state_q <= RD_RESP;
            end
            RD_RESP:
            begin
               if (rready)
               begin
                  rvalid_q <= 1'b0;
                  arready_q <= 1'b1;
                  rd_state_q <= RD_IDLE;
               end
            end
            default:
               rd_state_q <= RD_IDLE;
         endcase
      end
   end

   // Register file and the four phase execution sequence.
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ext_en_q <= `RST_CTRL_EXT;
         instr_q <= `RST_INSTR;
         wreg_q <= `RST_WREG;
         c_q <= `RST_FLAG;
         z_q <= `RST_FLAG;
         n_q <= `RST_FLAG;
         bad_q <= `RST_FLAG;
         busy_q <= 1'b0;
         phase_q <= `PH_DECODE;
         bank_q <= {BANK_W{1'b0}};
         index_q <= {AW{1'b0}};
         faddr_q <= {AW{1'b0}};
         eaddr_q <= {AW{1'b0}};
         left_q <= 1'b0;
         carry_q <= 1'b0;
         dest_q <= 1'b0;
         res_q <= 8'h00;
         res_c_q <= 1'b0;
      end
      else if (busy_q)
      begin
         phase_q <= phase_q + 2'h1;
         case (phase_q)
            `PH_DECODE:
            begin
               eaddr_q <= eaddr_d;
               left_q <= kind[1];
               carry_q <= kind[0];
               dest_q <= instr_q[9];
               if (!kind[2])
               begin
                  bad_q <= 1'b1;
                  busy_q <= 1'b0;
                  phase_q <= `PH_DECODE;
               end
            end
            `PH_READ:
               res_q <= res_q;
            `PH_PROC:
            begin
               res_q <= res_d;
               res_c_q <= res_c_d;
            end
            `PH_WRITE:
            begin
               busy_q <= 1'b0;
               if (!dest_q)
               begin
                  wreg_q <= res_q;
               end
               if (carry_q)
               begin
                  c_q <= res_c_q;
               end
               n_q <= res_q[7];
               z_q <= (res_q == 8'h00);
            end
            default:
               phase_q <= `PH_DECODE;
         endcase
      end
      else if (wr_ok)
      begin
         case (awaddr_q)
            `ADDR_CTRL:
               if (wstrb_q[0])
               begin
                  ext_en_q <= wdata_q[`CTRL_EXT_BIT];
               end
            `ADDR_INSTR:
            begin
               instr_q <= instr_m[15:0];
               busy_q <= 1'b1;
               phase_q <= `PH_DECODE;
            end
            `ADDR_WREG:
               if (wstrb_q[0])
               begin
                  wreg_q <= wdata_q[7:0];
               end
            `ADDR_STATUS:
               if (wstrb_q[0])
               begin
                  c_q <= wdata_q[`ST_C_BIT];
                  z_q <= wdata_q[`ST_Z_BIT];
                  n_q <= wdata_q[`ST_N_BIT];
                  bad_q <= bad_q & ~wdata_q[`ST_BAD_BIT];
               end
            `ADDR_BANK:
               if (wstrb_q[0])
               begin
                  bank_q <= wdata_q[BANK_W-1:0];
               end
            `ADDR_INDEX:
               index_q <= index_m[AW-1:0];
            `ADDR_FADDR:
               faddr_q <= faddr_m[AW-1:0];
            default:
               bad_q <= bad_q;
         endcase
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;
endmodule
`default_nettype wire

// >>> tb/rotate_exec_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module rotate_exec_checker (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Write channels
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   // Read channels
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready
);
   logic [7:0] aw_q;
   logic [7:0] ar_q;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   always @(posedge aclk)
   begin
      if (awvalid && awready)
         aw_q <= awaddr;
      if (arvalid && arready)
         ar_q <= araddr;
   end
   property p_b_hold;
      bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid not held");
   property p_r_hold;
      rvalid && !rready |=> rvalid && $stable({rdata, rresp}); endproperty
   a_r_hold: assert property (p_r_hold) else $error("rvalid not held");
   property p_aw_wait;
      awvalid && awready |=> !awready until (bvalid && bready); endproperty
   a_aw_wait: assert property (p_aw_wait) else $error("address taken twice");
   property p_w_wait;
      wvalid && wready |=> !wready until (bvalid && bready); endproperty
   a_w_wait: assert property (p_w_wait) else $error("data taken twice");
   property p_ar_wait;
      arvalid && arready |=> (!arready) until (rvalid && rready); endproperty
   a_ar_wait: assert property (p_ar_wait) else $error("read taken twice");
   property p_b_lat;
      awvalid && awready && wvalid && wready |-> ##[1:7] bvalid; endproperty
   a_b_lat: assert property (p_b_lat) else $error("slow write");
   property p_r_lat;
      arvalid && arready && araddr[7:2] != 6'h07 |-> ##[1:3] rvalid;
   endproperty
   a_r_lat: assert property (p_r_lat) else $error("late read answer");
   property p_b_code;
      bvalid |-> bresp == (aw_q[7:5] == 3'h0 ? 2'h0 : 2'h2); endproperty
   a_b_code: assert property (p_b_code) else $error("wrong write code");
   property p_r_code;
      rvalid |-> (ar_q[7:5] == 3'h0 ? rresp == 2'h0
         : {rresp, rdata} == {2'h2, 32'h0}); endproperty
   a_r_code: assert property (p_r_code) else $error("wrong read answer");
endmodule
bind rotate_exec rotate_exec_checker chk_u (.aclk, .aresetn, .awaddr,
   .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
   .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
`default_nettype wire

// >>> tb/axi_lite_master.sv
`timescale 1ns/1ps
`default_nettype none
module axi_lite_master (
   // Clock
   input wire logic aclk,
   // Write channels
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   // Read channels
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   // Cycles before bready or rready rises, so answers must wait.
   int slow = 0;
   initial
   begin
      {awaddr, awvalid, wdata, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // A released line shows the inverse of its last value.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] resp);
      int n;
      resp = 2'h3;
      @(posedge aclk);
      {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
      bready <= (slow == 0);
      for (n = 1; n < 60; n++)
      begin
         @(posedge aclk);
         if (bvalid && bready)
         begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
         awvalid <= awvalid && !awready;
         wvalid <= wvalid && !wready;
         awaddr <= (awvalid && awready) ? ~a : awaddr;
         wdata <= (wvalid && wready) ? ~d : wdata;
         bready <= bready || (n >= slow);
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] resp);
      int n;
      resp = 2'h3;
      d = 32'h0;
      @(posedge aclk);
      {araddr, arvalid} <= {a, 1'b1};
      rready <= (slow == 0);
      for (n = 1; n < 60; n++)
      begin
         @(posedge aclk);
         if (rvalid && rready)
         begin
            {d, resp} = {rdata, rresp};
            rready <= 1'b0;
            break;
         end
         arvalid <= arvalid && !arready;
         araddr <= (arvalid && arready) ? ~a : araddr;
         rready <= rready || (n >= slow);
      end
   endtask
endmodule
`default_nettype wire

// >>> tb/bit_rotate_execution_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bit_rotate_execution_tb_top;
   logic aclk;
   logic aresetn;
   wire [7:0] awaddr, araddr;
   wire [31:0] wdata, rdata;
   wire [1:0] bresp, rresp;
   wire awvalid, awready, wvalid, wready, bvalid, bready;
   wire arvalid, arready, rvalid, rready;
   wire [2:0] awprot = 3'h0;
   wire [2:0] arprot = 3'h0;
   wire [3:0] wstrb = 4'hf;
   int n_errors = 0;
   int comparisons = 0;
   int i;
   logic [5:0] ops [4] = '{6'h0d, 6'h11, 6'h0c, 6'h10};
   logic [31:0] rv;
   logic [1:0] rs, nz;
   logic [10:0] ex;
   logic [11:0] idx;
   logic [7:0] f, v, w0;
   logic [3:0] bank;
   logic dst, acc, c, ext;
   rotate_exec #(.BANK_W(4)) dut_u (.aclk, .aresetn, .awaddr, .awprot,
      .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready);
   axi_lite_master m_u (.aclk, .awaddr, .awvalid, .awready, .wdata, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready);
   initial
   begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      comparisons++;
      if (seen !== want)
      begin
         n_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic close_out;
      $display("compares %0d, mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic settle;
      if (rs === 2'h3)
      begin
         n_errors++;
         $display("unexpected at %0t: no bus answer", $time);
         close_out;
      end
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      m_u.wr(a, d, rs);
      settle;
   endtask
   task automatic r(input logic [7:0] a);
      m_u.rd(a, rv, rs);
      settle;
   endtask
   task automatic wait_idle;
      for (int k = 0; k < 4; k++)
      begin
         r(8'h0c);
         if (rv[7] === 1'b0)
            break;
      end
      check(32'(rv[7]), 32'h0);
   endtask
   function automatic logic [10:0] rot(input logic [5:0] o,
      input logic [7:0] x, input logic ci);
      logic [7:0] yl, yr, y;
      yl = {x[6:0], o[4] ? x[7] : ci};
      yr = {o[4] ? x[0] : ci, x[7:1]};
      y = o[0] ? yl : yr;
      return {o[4] ? ci : x[o[0] ? 7 : 0], y[7], y == 8'h00, y};
   endfunction
   function automatic logic [11:0] eff(input logic ab, input logic [7:0] fa);
      if (ab)
         return {bank, fa};
      if (fa > 8'h5f)
         return {4'hf, fa};
      return ext ? idx + {4'h0, fa} : {4'h0, fa};
   endfunction
   initial
   begin
      aresetn = 1'b0;
      rv = $urandom(32'h0d54);
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      r(8'h00);
      check(rv, 32'h0);
      r(8'h0c);
      check(rv, 32'h0);
      $display("test reset values done");
      for (i = 0; i < 64; i++)
      begin
         {dst, acc, c, ext, nz, bank} = 10'($urandom);
         {f, v, w0, idx} = 36'({$urandom, $urandom});
         f = (i % 8 == 0) ? 8'h5f : (i % 8 == 1) ? 8'h60 : f;
         m_u.slow = $urandom_range(2);
         w(8'h00, 32'(ext));
         w(8'h10, 32'(bank));
         w(8'h14, 32'(idx));
         w(8'h18, 32'(eff(acc, f)));
         w(8'h1c, 32'(v));
         w(8'h08, 32'(w0));
         w(8'h0c, 32'({nz, c}));
         w(8'h04, 32'({ops[i % 4], dst, acc, f}));
         wait_idle;
         ex = rot(ops[i % 4], v, c);
         check(32'(rv[0]), 32'(ex[10]));
         check(32'(rv[7:1]), 32'(ex[9:8]));
         r(8'h08);
         check(32'(rv[7:0]), 32'(dst ? w0 : ex[7:0]));
         r(8'h1c);
         check(rv, 32'(dst ? ex[7:0] : v));
      end
      $display("test rotate forms done");
      w(8'h04, 32'h0000fc00);
      wait_idle;
      check(32'(rv[7:6]), 32'h1);
      r(8'h08);
      check(32'(rv[7:0]), 32'(dst ? w0 : ex[7:0]));
      w(8'h0c, 32'h40);
      r(8'h0c);
      check(32'(rv[7:0]), 32'h0);
      w(8'h20, 32'h0);
      check(32'(rs), 32'h2);
      r(8'hfc);
      check(32'(rs), 32'h2);
      check(rv, 32'h0);
      $display("test refusals done");
      close_out;
   end
endmodule
`default_nettype wire
